// ==== logic/dif_defs.svh ====
/*
 * Constants for the DDR input port and its elastic sample buffer:
 * pointer reset addresses, sync select bit positions and the serial sync select code.
 * Assumes it is included by bare name from the package and the design file.
 */
// Contract
// - Word mode: 16-bit I then Q interleaved.
// - Byte mode: I high, I low, Q high, Q low.
// - Capture both edges, build 32-bit I/Q sample.
// - Sync strobes sampled on rising data edges only.
// - Byte mode: sync rising edge aligns byte boundaries.
// - Parity enabled: frame at next falling edge.
// - Buffer holds 8 samples of two 16-bit channels.
// - Write/read at pointers, each advances one per access.
// - Read rate is converter clock over interpolation, halved-word.
// - Pointer reset: write 0, read programmable, default 4.
// - Selected write sync rising edge resets write pointer.
// - Read sync selectable; write sync recaptured for reads.
// - Output strobe, sampled by converter clock, resets reads.
// - Pointers wrap by themselves; one reset suffices.
// - Word mode serial sync resets both pointers.
// - Buffer bypass by enable with read select. Code: elasticBufferEnable low alone bypasses; read select plays no part.
// - Dual source: write from frame/sync, read from strobe.
// - Bypass passes data straight, pointers ignored.
`ifndef DIF_DEFS_SVH
`define DIF_DEFS_SVH
`define DIF_WR_RESET_ADDR 3'h0
`define DIF_RD_RESET_ADDR_DEFAULT 3'h4
`define DIF_SEL_SYNC 0
`define DIF_SEL_FRAME 1
`define DIF_SEL_OUTPUT_STROBE_INPUT 2
`define DIF_SEL_SIF 3
`define DIF_SIF_SELECT_CODE 4'h8
`endif

// ==== logic/dif_pkg.sv ====
/*
 * Types shared by the DDR input port.
 * Assumes dif_defs.svh is reachable on the include path.
 */
`default_nettype none
`include "dif_defs.svh"
package dif_pkg;
	// Byte-mode phase of the current sample, Gray coded along the byte order.
	typedef enum logic [1:0] {
		BYTE_I_HI = 2'h0,
		BYTE_I_LO = 2'h1,
		BYTE_Q_HI = 2'h3,
		BYTE_Q_LO = 2'h2
	} dif_byte_e;
	typedef logic [31:0] dif_sample_t;
endpackage
`default_nettype wire

// ==== logic/dif_input_port.sv ====
/*
 * DDR input port with elastic sample buffer: the buffer module and the port top.
 * Assumes every input is synchronous to sys_clk, which runs well above both the data
 * clock and the converter clock so that their edges can be seen as level changes.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dif_defs.svh"

module dif_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [WIDTH-1:0] wrData,
	output logic rdValid,
	input wire logic rdReady,
	output logic [WIDTH-1:0] rdData,
	input wire logic wrPtrReset,
	input wire logic rdPtrReset,
	input wire logic [$clog2(DEPTH)-1:0] rdResetPos,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic doWr, doRd;

	// The wrap bit of the read pointer is set on rdPtrReset (reset clears it) so the gap reads as occupancy.
	assign level = wrPtr_r - rdPtr_r;
	assign wrReady = (level < (AW+1)'(DEPTH));
	assign rdValid = (level != '0);
	assign doWr = wrValid & wrReady & clkEn;
	assign doRd = rdValid & rdReady & clkEn;
	assign rdData = mem[rdPtr_r[AW-1:0]];

	always_comb begin
		wrPtr_nxt = wrPtr_r;
		rdPtr_nxt = rdPtr_r;
		if (wrPtrReset) begin
			wrPtr_nxt = (AW+1)'(`DIF_WR_RESET_ADDR);
		end else if (doWr) begin
			wrPtr_nxt = wrPtr_r + 1'b1;
		end
		if (rdPtrReset) begin
			rdPtr_nxt = {1'b1, rdResetPos};
		end else if (doRd) begin
			rdPtr_nxt = rdPtr_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end else if (clkEn) begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
		end
	end

	// The memory has no reset, so a word read before it was first written is undefined.
	always_ff @(posedge sys_clk) begin
		if (doWr) begin
			mem[wrPtr_r[AW-1:0]] <= wrData;
		end
	end
endmodule

module dif_input_port import dif_pkg::*; #(
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic wordModeSel,
	input wire logic inputDdrClock,
	input wire logic [15:0] ddrData,
	input wire logic frameIn,
	input wire logic syncIn,
	input wire logic serialIfSync,
	input wire logic converterClock,
	input wire logic outputStrobeInput,
	input wire logic parityFromFrameEnable,
	input wire logic elasticBufferEnable,
	input wire logic [3:0] writePtrSyncSelect,
	input wire logic [3:0] readPtrSyncSelect,
	input wire logic [1:0] formatterSyncSelect,
	input wire logic [2:0] readPtrResetPosition,
	input wire logic [4:0] interpolation,
	input wire logic outReady,
	output logic sampleReady,
	output logic [31:0] outData,
	output logic outValid,
	output logic blockParity,
	output logic blockParityValid,
	output logic [3:0] fifoLevel
);
	logic ddrPrev_r, ddrPrev_nxt, frameS_r, frameS_nxt, syncS_r, syncS_nxt, sifPrev_r, sifPrev_nxt;
	dif_byte_e phase_r, phase_nxt, phaseCur;
	logic [15:0] iHold_r, iHold_nxt;
	logic [7:0] qHi_r, qHi_nxt;
	dif_sample_t sample_r, sample_nxt;
	logic sampleValid_r, sampleValid_nxt, parity_r, parity_nxt, parityValid_r, parityValid_nxt;
	logic ddrRise, ddrFall, frameRise, syncRise, sifRise, sifOk, wrSyncEv, xferEv;
	logic xTog_r, xTog_nxt, xS1_r, xS2_r, xS3_r;
	logic convPrev_r, convPrev_nxt, ostrS_r, ostrS_nxt, convRise, ostrRise, readTick, rdGo, rdSyncEv;
	logic [4:0] interpEff;
	logic [5:0] divCnt_r, divCnt_nxt, divLen;
	dif_sample_t outData_r, outData_nxt, fifoRdData;
	logic outValid_r, outValid_nxt, fifoRdValid;

	assign ddrRise = inputDdrClock & ~ddrPrev_r;
	assign ddrFall = ~inputDdrClock & ddrPrev_r;
	// Strobe edges are judged only against the level seen at the previous rising edge.
	assign frameRise = ddrRise & frameIn & ~frameS_r;
	assign syncRise = ddrRise & syncIn & ~syncS_r;
	// Serial sync is a control level, not a data-bus strobe, so its edge is taken on the system clock.
	assign sifRise = serialIfSync & ~sifPrev_r;
	assign sifOk = wordModeSel & formatterSyncSelect[1];
	assign wrSyncEv = (writePtrSyncSelect[`DIF_SEL_SYNC] & syncRise)
		| (writePtrSyncSelect[`DIF_SEL_FRAME] & frameRise)
		| (writePtrSyncSelect == `DIF_SIF_SELECT_CODE && readPtrSyncSelect == `DIF_SIF_SELECT_CODE
			&& sifOk && sifRise);

	always_comb begin
		ddrPrev_nxt = inputDdrClock;
		sifPrev_nxt = serialIfSync;
		frameS_nxt = ddrRise ? frameIn : frameS_r;
		syncS_nxt = ddrRise ? syncIn : syncS_r;
		iHold_nxt = iHold_r;
		qHi_nxt = qHi_r;
		sample_nxt = sample_r;
		sampleValid_nxt = 1'b0;
		phase_nxt = phase_r;
		parity_nxt = parity_r;
		parityValid_nxt = 1'b0;
		// A fresh sync edge forces this byte to be the I high byte.
		phaseCur = (frameRise | syncRise) ? BYTE_I_HI : phase_r;
		if (wordModeSel) begin
			if (ddrRise) begin
				iHold_nxt = ddrData;
			end
			if (ddrFall) begin
				sample_nxt = {iHold_r, ddrData};
				sampleValid_nxt = 1'b1;
			end
		end else if (ddrRise | ddrFall) begin
			unique case (phaseCur)
				BYTE_I_HI: begin
					iHold_nxt[15:8] = ddrData[7:0];
					phase_nxt = BYTE_I_LO;
				end
				BYTE_I_LO: begin
					iHold_nxt[7:0] = ddrData[7:0];
					phase_nxt = BYTE_Q_HI;
				end
				BYTE_Q_HI: begin
					qHi_nxt = ddrData[7:0];
					phase_nxt = BYTE_Q_LO;
				end
				BYTE_Q_LO: begin
					sample_nxt = {iHold_r, qHi_r, ddrData[7:0]};
					sampleValid_nxt = 1'b1;
					phase_nxt = BYTE_I_HI;
				end
			endcase
		end
		if (parityFromFrameEnable && ddrFall) begin
			parity_nxt = frameIn;
			parityValid_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ddrPrev_r <= 1'b0;
			sifPrev_r <= 1'b0;
			frameS_r <= 1'b0;
			syncS_r <= 1'b0;
			iHold_r <= 16'h0000;
			qHi_r <= 8'h00;
			sample_r <= 32'h00000000;
			sampleValid_r <= 1'b0;
			phase_r <= BYTE_I_HI;
			parity_r <= 1'b0;
			parityValid_r <= 1'b0;
		end else if (clkEn) begin
			ddrPrev_r <= ddrPrev_nxt;
			sifPrev_r <= sifPrev_nxt;
			frameS_r <= frameS_nxt;
			syncS_r <= syncS_nxt;
			iHold_r <= iHold_nxt;
			qHi_r <= qHi_nxt;
			sample_r <= sample_nxt;
			sampleValid_r <= sampleValid_nxt;
			phase_r <= phase_nxt;
			parity_r <= parity_nxt;
			parityValid_r <= parityValid_nxt;
		end
	end

	// Write-side sync travels to the read side as a toggle; its phase there is ambiguous by design.
	assign xferEv = xS2_r ^ xS3_r;
	assign xTog_nxt = xTog_r ^ ((readPtrSyncSelect[`DIF_SEL_SYNC] & syncRise)
		| (readPtrSyncSelect[`DIF_SEL_FRAME] & frameRise));

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			xTog_r <= 1'b0;
			xS1_r <= 1'b0;
			xS2_r <= 1'b0;
			xS3_r <= 1'b0;
		end else if (clkEn) begin
			xTog_r <= xTog_nxt;
			xS1_r <= xTog_r;
			xS2_r <= xS1_r;
			xS3_r <= xS2_r;
		end
	end

	assign convRise = converterClock & ~convPrev_r;
	assign ostrRise = convRise & outputStrobeInput & ~ostrS_r;
	assign interpEff = (interpolation == 5'h00) ? 5'h01 : interpolation;
	assign divLen = wordModeSel ? {interpEff, 1'b0} : {1'b0, interpEff};
	// Comparing with at least the end point keeps a shortened interpolation from stranding the counter.
	assign readTick = convRise & (divCnt_r >= divLen - 6'h01);
	assign rdGo = readTick & outReady;
	assign rdSyncEv = (readPtrSyncSelect[`DIF_SEL_OUTPUT_STROBE_INPUT] & ostrRise)
		| xferEv
		| (readPtrSyncSelect == `DIF_SIF_SELECT_CODE && writePtrSyncSelect == `DIF_SIF_SELECT_CODE
			&& sifOk && sifRise);

	always_comb begin
		convPrev_nxt = converterClock;
		ostrS_nxt = convRise ? outputStrobeInput : ostrS_r;
		divCnt_nxt = divCnt_r;
		// A read reset also restarts the divider so the output phase follows the strobe.
		if (rdSyncEv) begin
			divCnt_nxt = 6'h00;
		end else if (convRise) begin
			divCnt_nxt = readTick ? 6'h00 : divCnt_r + 6'h01;
		end
		outData_nxt = outData_r;
		outValid_nxt = 1'b0;
		if (!elasticBufferEnable) begin
			if (sampleValid_r) begin
				outData_nxt = sample_r;
				outValid_nxt = 1'b1;
			end
		end else if (rdGo && fifoRdValid) begin
			outData_nxt = fifoRdData;
			outValid_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			convPrev_r <= 1'b0;
			ostrS_r <= 1'b0;
			divCnt_r <= 6'h00;
			outData_r <= 32'h00000000;
			outValid_r <= 1'b0;
		end else if (clkEn) begin
			convPrev_r <= convPrev_nxt;
			ostrS_r <= ostrS_nxt;
			divCnt_r <= divCnt_nxt;
			outData_r <= outData_nxt;
			outValid_r <= outValid_nxt;
		end
	end

	// A sample arriving while the buffer is full is dropped; sampleReady shows it to the source.
	dif_fifo #(
		.WIDTH(32),
		.DEPTH(DEPTH)
	) buffer (
		.sys_clk(sys_clk),
		.reset(reset),
		.clkEn(clkEn),
		.wrValid(sampleValid_r & elasticBufferEnable),
		.wrReady(sampleReady),
		.wrData(sample_r),
		.rdValid(fifoRdValid),
		.rdReady(rdGo & elasticBufferEnable),
		.rdData(fifoRdData),
		.wrPtrReset(wrSyncEv),
		.rdPtrReset(rdSyncEv),
		.rdResetPos(readPtrResetPosition),
		.level(fifoLevel)
	);

	assign outData = outData_r;
	assign outValid = outValid_r;
	assign blockParity = parity_r;
	assign blockParityValid = parityValid_r;
endmodule
`default_nettype wire

// ==== verif/dif_input_port_assertions.sv ====
/* Checker for the DDR input port: parity capture, bypass path, buffer level and pointer resets.
   Assumes it is bound to dif_input_port and that clkEn is held high. */
`timescale 1ns/100ps
`default_nettype none
module dif_input_port_assertions #(
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic wordModeSel,
	input wire logic inputDdrClock,
	input wire logic [15:0] ddrData,
	input wire logic frameIn,
	input wire logic serialIfSync,
	input wire logic parityFromFrameEnable,
	input wire logic elasticBufferEnable,
	input wire logic [3:0] writePtrSyncSelect,
	input wire logic [3:0] readPtrSyncSelect,
	input wire logic [1:0] formatterSyncSelect,
	input wire logic [2:0] readPtrResetPosition,
	input wire logic outReady,
	input wire logic sampleReady,
	input wire logic [31:0] outData,
	input wire logic outValid,
	input wire logic blockParity,
	input wire logic blockParityValid,
	input wire logic [3:0] fifoLevel
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// The edge detector restarts from a low level, so the cycle after reset is left out.
	sequence dataFall;
		$fell(inputDdrClock) && !$past(reset);
	endsequence
	ready_level_a: assert property (sampleReady == (fifoLevel < DEPTH))
		else $error("ready does not match level");
	parity_capture_a: assert property (dataFall ##0 parityFromFrameEnable |=> blockParityValid && blockParity == $past(frameIn))
		else $error("parity not captured");
	parity_pulse_a: assert property (blockParityValid |=> !blockParityValid)
		else $error("parity valid too long");
	parity_cause_a: assert property (blockParityValid |-> $past(parityFromFrameEnable) && !$past(inputDdrClock) && $past(inputDdrClock, 2))
		else $error("parity without falling edge");
	bypass_word_a: assert property (dataFall ##0 (wordModeSel && !elasticBufferEnable) |-> ##2 outValid && outData[15:0] == $past(ddrData, 2))
		else $error("bypass sample missing");
	out_pulse_a: assert property (outValid |=> !outValid)
		else $error("output valid too long");
	read_nonempty_a: assert property (outValid && $past(elasticBufferEnable) |-> $past(fifoLevel) != 4'h0 && $past(outReady))
		else $error("read from empty or stalled buffer");
	serial_reset_a: assert property ($rose(serialIfSync) && !$past(reset) && wordModeSel && formatterSyncSelect[1] && writePtrSyncSelect == 4'h8 && readPtrSyncSelect == 4'h8 |=> fifoLevel == 4'h8 - {1'b0, readPtrResetPosition})
		else $error("serial sync level wrong");
endmodule
`default_nettype wire

// ==== verif/dif_source_model.sv ====
/* Behavioural sample source driving the DDR bus.
   Assumes one process at a time calls its tasks. */
`timescale 1ns/100ps
`default_nettype none
module dif_source_model (
	input wire logic sys_clk,
	output logic ddrClk,
	output logic [15:0] ddrData,
	output logic frameOut,
	output logic syncOut
);
	initial begin
		ddrClk = 1'b0;
		ddrData = 16'h0;
		frameOut = 1'b0;
		syncOut = 1'b0;
	end
	// Each level lasts four system cycles so that the port sees every edge.
	task automatic edgeOut(input logic [15:0] d, input logic fr, input logic sy);
		@(posedge sys_clk);
		ddrData <= d;
		frameOut <= fr;
		syncOut <= sy;
		ddrClk <= ~ddrClk;
		repeat (3) @(posedge sys_clk);
	endtask
	// Released data shows its inverse, so a late sample cannot pass by luck.
	task automatic idleBus();
		@(posedge sys_clk);
		ddrData <= ~ddrData;
		frameOut <= 1'b0;
	endtask
	task automatic sendWord(input logic [15:0] i, input logic [15:0] q, input logic par);
		edgeOut(i, 1'b0, 1'b0);
		edgeOut(q, par, 1'b0);
		idleBus();
	endtask
	task automatic sendByte(input logic [15:0] i, input logic [15:0] q, input logic par, input logic sy);
		edgeOut({8'h5a, i[15:8]}, 1'b0, sy);
		edgeOut({8'h5a, i[7:0]}, 1'b0, 1'b0);
		edgeOut({8'h5a, q[15:8]}, 1'b0, 1'b0);
		edgeOut({8'h5a, q[7:0]}, par, 1'b0);
		idleBus();
	endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
/* Self-checking bench for the DDR input port: bypass rows, buffer fill and drain, pointer resets.
   Assumes the source model and the checker are compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct {logic mode; logic [15:0] i; logic [15:0] q; logic par; logic sy;} dif_row_s;
	dif_row_s rows [4] = '{'{1'b1, 16'h8001, 16'h7ffe, 1'b1, 1'b0}, '{1'b1, 16'h0000, 16'hffff, 1'b0, 1'b0},
		'{1'b0, 16'ha55a, 16'h3cc3, 1'b1, 1'b1}, '{1'b0, 16'h1234, 16'hfedc, 1'b0, 1'b0}};
	logic sys_clk, reset, wordModeSel, inputDdrClock, frameIn, syncIn, serialIfSync, converterClock;
	logic outputStrobeInput, elasticBufferEnable, outReady, sampleReady, outValid, blockParity;
	logic parityFromFrameEnable, blockParityValid;
	logic [15:0] ddrData;
	logic [3:0] writePtrSyncSelect, readPtrSyncSelect, fifoLevel;
	logic [1:0] formatterSyncSelect;
	logic [2:0] readPtrResetPosition;
	logic [31:0] outData;
	logic [31:0] got [$];
	int errors = 0;
	int checksDone = 0;
	int parityPulses = 0;
	dif_source_model src (.sys_clk, .ddrClk(inputDdrClock), .ddrData, .frameOut(frameIn), .syncOut(syncIn));
	dif_input_port uut (.sys_clk, .reset, .clkEn(1'b1), .wordModeSel, .inputDdrClock, .ddrData, .frameIn,
		.syncIn, .serialIfSync, .converterClock, .outputStrobeInput, .parityFromFrameEnable,
		.elasticBufferEnable, .writePtrSyncSelect, .readPtrSyncSelect, .formatterSyncSelect,
		.readPtrResetPosition, .interpolation(5'h1), .outReady, .sampleReady, .outData, .outValid,
		.blockParity, .blockParityValid, .fifoLevel);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (outValid === 1'b1) got.push_back(outData);
	always @(posedge sys_clk) if (blockParityValid === 1'b1) parityPulses++;
	task wrap_up();
		$display("checks %0d errors %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task check(input logic ok, input string msg);
		checksDone++;
		if (ok !== 1'b1) begin
			errors++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task popOut(input logic [31:0] exp);
		int n;
		n = 0;
		while (got.size() == 0 && n < 60) begin
			@(posedge sys_clk);
			n++;
		end
		if (got.size() == 0) begin
			errors++;
			$display("MISMATCH %0t no output sample", $time);
			wrap_up();
		end else begin
			check(got.pop_front() === exp, "output sample");
		end
	endtask
	task cnvTicks(input int n);
		repeat (n) begin
			@(posedge sys_clk) converterClock <= ~converterClock;
			repeat (2) @(posedge sys_clk);
		end
	endtask
	initial begin
		{reset, wordModeSel, serialIfSync, converterClock, outputStrobeInput, elasticBufferEnable, outReady} = 7'h41;
		{writePtrSyncSelect, readPtrSyncSelect, formatterSyncSelect, readPtrResetPosition} = 13'h0004;
		parityFromFrameEnable = 1'b1;
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1 check(outValid === 1'b0 && fifoLevel === 4'h0 && sampleReady === 1'b1 && outData === 32'h0, "reset");
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk) wordModeSel <= rows[k].mode;
			if (rows[k].mode) src.sendWord(rows[k].i, rows[k].q, rows[k].par);
			else src.sendByte(rows[k].i, rows[k].q, rows[k].par, rows[k].sy);
			popOut({rows[k].i, rows[k].q});
			check(blockParity === rows[k].par, "parity bit");
		end
		check(parityPulses == 6, "parity pulse count");
		@(posedge sys_clk) wordModeSel <= 1'b1;
		elasticBufferEnable <= 1'b1;
		for (int k = 0; k < 9; k++) src.sendWord(16'(k + 16'h1000), 16'(k + 16'h2000), 1'b0);
		repeat (3) @(posedge sys_clk);
		#1 check(sampleReady === 1'b0 && fifoLevel === 4'h8, "full buffer");
		@(posedge sys_clk) outReady <= 1'b1;
		cnvTicks(16);
		check(got.size() == 4, "read rate");
		@(posedge sys_clk) outReady <= 1'b0;
		cnvTicks(8);
		check(got.size() == 4, "stalled reads");
		@(posedge sys_clk) outReady <= 1'b1;
		cnvTicks(24);
		for (int k = 0; k < 8; k++) popOut({16'(k + 16'h1000), 16'(k + 16'h2000)});
		check(got.size() == 0 && fifoLevel === 4'h0, "drained buffer");
		@(posedge sys_clk) {writePtrSyncSelect, readPtrSyncSelect, formatterSyncSelect, outReady} <= 11'h444;
		@(posedge sys_clk) serialIfSync <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 check(fifoLevel === 4'h4, "serial sync level");
		@(posedge sys_clk) {serialIfSync, readPtrSyncSelect, readPtrResetPosition, outputStrobeInput} <= 9'h043;
		cnvTicks(2);
		repeat (2) @(posedge sys_clk);
		#1 check(fifoLevel === 4'h7, "strobe reset level");
		@(posedge sys_clk) parityFromFrameEnable <= 1'b0;
		src.sendWord(16'h0f0f, 16'hf0f0, 1'b1);
		check(parityPulses == 15 && blockParity === 1'b0, "parity while disabled");
		@(posedge sys_clk) reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1 check(outValid === 1'b0 && fifoLevel === 4'h0 && outData === 32'h0, "mid-run reset");
		wrap_up();
	end
endmodule
bind dif_input_port dif_input_port_assertions #(.DEPTH(DEPTH)) chk (.sys_clk, .reset, .wordModeSel, .inputDdrClock,
	.ddrData, .frameIn, .serialIfSync, .parityFromFrameEnable, .elasticBufferEnable, .writePtrSyncSelect,
	.readPtrSyncSelect, .formatterSyncSelect, .readPtrResetPosition, .outReady, .sampleReady, .outData,
	.outValid, .blockParity, .blockParityValid, .fifoLevel);
`default_nettype wire
